// ===== core/cam_ctrl_pkg.sv
// Shared constants and types for the camera control register bank
package cam_ctrl_pkg;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] OFS_STREAM   = 8'h00;   // Stream channel open
   localparam logic [7:0] OFS_EVENT    = 8'h04;   // Event notification enable
   localparam logic [7:0] OFS_TEST_EVT = 8'h08;   // Test event trigger, write only
   localparam logic [7:0] OFS_REINIT   = 8'h0c;   // Whole unit reinit, write only
   localparam logic [7:0] OFS_FORMAT   = 8'h10;   // Readout format choice
   localparam logic [7:0] OFS_STATUS   = 8'h14;   // Busy and refused flags
   localparam logic [7:0] OFS_LABEL    = 8'h20;   // User label, 8 words
   localparam logic [7:0] OFS_MAKER    = 8'h40;   // Maker name, 4 words
   localparam logic [7:0] OFS_MODEL    = 8'h50;   // Model name, 4 words
   localparam logic [7:0] OFS_INFO     = 8'h60;   // Maker info, 4 words
   localparam logic [7:0] OFS_VERSION  = 8'h70;   // Unit version, 2 words
   localparam logic [7:0] OFS_SERIAL   = 8'h78;   // Serial number, 2 words

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int         BIT_STAT_BUSY    = 0;     // Stream data in flight
   localparam int         BIT_STAT_REFUSED = 1;     // Format write refused
   localparam int         LABEL_WORDS      = 8;     // 32 characters of label
   localparam logic       RST_STREAM       = 1'b0;  // Channel closed
   localparam logic       RST_EVENT        = 1'b0;  // Notification off
   localparam logic       RST_REFUSED      = 1'b0;  // No refusal seen

   // ************************************************************
   // Enumerations
   // ************************************************************
   typedef enum logic [1:0] {
      roi_readout_choice   = 2'b00,
      pixel_summing_choice = 2'b01,
      line_skipping_choice = 2'b10
   } readout_format_t;

   localparam readout_format_t RST_FORMAT = roi_readout_choice;

   typedef enum logic [1:0] {
      ST_RESTORE = 2'b00,
      ST_IDLE    = 2'b01
   } label_state_t;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic       valid;  // Transfer pending in data phase
      logic       write;  // Write when set
      logic [7:0] ofs;    // Byte offset inside the bank
   } ahb_req_t;

   typedef struct packed {
      logic send;  // One-cycle event packet request
      logic test;  // Packet is the test event
   } evt_out_t;

endpackage

// ===== core/label_store.sv
// Retained user label storage with write-through to non-volatile memory
`timescale 1ns/10ps
module label_store #(
   parameter int WORDS = 8
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_reset,
   input  wire logic                     i_ce,
   input  wire logic                     i_wr_en,
   input  wire logic [$clog2(WORDS)-1:0] i_wr_idx,
   input  wire logic [31:0]              i_wr_data,
   input  wire logic [$clog2(WORDS)-1:0] i_rd_idx,
   output logic      [31:0]              o_rd_data,
   output logic                          o_busy,
   output logic                          o_nv_we,
   output logic      [$clog2(WORDS)-1:0] o_nv_addr,
   output logic      [31:0]              o_nv_wdata,
   input  wire logic [31:0]              i_nv_rdata
);
   import cam_ctrl_pkg::*;

   localparam int AW = $clog2(WORDS);

   logic [31:0]        mem [WORDS];      // Label words, never cleared by reset
   label_state_t       state_ff;         // Restore or idle
   label_state_t       nxt_state;
   logic [AW-1:0]      cnt_ff;           // Restore word index
   logic [AW-1:0]      nxt_cnt;
   logic               nv_we_ff;         // Registered NV write strobe
   logic               nxt_nv_we;
   logic [AW-1:0]      nv_addr_ff;
   logic [AW-1:0]      nxt_nv_addr;
   logic [31:0]        nv_wdata_ff;
   logic [31:0]        nxt_nv_wdata;

   // ************************************************************
   // Read port
   // ************************************************************
   // Bypass so a read issued with a write to the same word sees new data
   always_comb begin
      if (i_wr_en && (i_wr_idx == i_rd_idx)) begin
         o_rd_data = i_wr_data;
      end else begin
         o_rd_data = mem[i_rd_idx];
      end
   end

   assign o_busy     = (state_ff == ST_RESTORE);
   assign o_nv_we    = nv_we_ff;
   assign o_nv_addr  = nv_addr_ff;
   assign o_nv_wdata = nv_wdata_ff;

   // ************************************************************
   // Restore walk and write-through next state
   // ************************************************************
   // NV read data is taken at the edge ending the cycle its address stands
   always_comb begin
      nxt_state    = state_ff;
      nxt_cnt      = cnt_ff;
      nxt_nv_we    = 1'b0;
      nxt_nv_addr  = nv_addr_ff;
      nxt_nv_wdata = nv_wdata_ff;
      case (state_ff)
         ST_RESTORE: begin
            nxt_cnt     = cnt_ff + 1'b1;
            nxt_nv_addr = cnt_ff + 1'b1;
            if (cnt_ff == AW'(WORDS - 1)) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            // Every label write is copied out so it survives power loss
            if (i_wr_en) begin
               nxt_nv_we    = 1'b1;
               nxt_nv_addr  = i_wr_idx;
               nxt_nv_wdata = i_wr_data;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_ff    <= ST_RESTORE;
         cnt_ff      <= '0;
         nv_we_ff    <= 1'b0;
         nv_addr_ff  <= '0;
         nv_wdata_ff <= 32'h0;
      end else if (i_ce) begin
         state_ff    <= nxt_state;
         cnt_ff      <= nxt_cnt;
         nv_we_ff    <= nxt_nv_we;
         nv_addr_ff  <= nxt_nv_addr;
         nv_wdata_ff <= nxt_nv_wdata;
      end
   end

   // ************************************************************
   // Storage array
   // ************************************************************
   // No reset on the array: contents are reloaded from NV after reset
   always_ff @(posedge i_clk) begin
      if (!i_reset && i_ce) begin
         if (state_ff == ST_RESTORE) begin
            mem[cnt_ff] <= i_nv_rdata;
         end else if (i_wr_en) begin
            mem[i_wr_idx] <= i_wr_data;
         end
      end
   end

endmodule

// ===== core/camera_control_registers.sv
// Camera control register bank on an AHB-Lite slave port
`timescale 1ns/10ps

// Notes on behaviour
// - Stream bit opens and closes stream channel
// - Event packets leave only while enabled
// - Test trigger write sends one event
// - User label stored and kept in NV
// - Identity strings readable, never writable
// - Format: 0 ROI default, 1 bin, 2 skip
// - Format writes ignored while stream data flows
module camera_control_registers #(
   parameter logic [127:0] MAKER_NAME = 128'h6d616b65725f6e616d655f5f5f5f5f5f,
   parameter logic [127:0] MODEL_NAME = 128'h6d6f64656c5f6e616d655f5f5f5f5f5f,
   parameter logic [127:0] MAKER_INFO = 128'h6d616b65725f696e666f5f5f5f5f5f5f,
   parameter logic [63:0]  UNIT_VER   = 64'h76657273696f6e30,
   parameter logic [63:0]  SERIAL_NUM = 64'h3030303030303031
) (
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RESET,
   input  wire logic        I_CE,
   // AHB-Lite slave
   input  wire logic        I_HSEL,
   input  wire logic [31:0] I_HADDR,
   input  wire logic [1:0]  I_HTRANS,
   input  wire logic        I_HWRITE,
   input  wire logic [2:0]  I_HSIZE,
   input  wire logic [31:0] I_HWDATA,
   input  wire logic        I_HREADY,
   output logic             O_HREADYOUT,
   output logic      [31:0] O_HRDATA,
   output logic             O_HRESP,
   // Camera side
   input  wire logic        I_STREAM_BUSY,
   input  wire logic        I_EVT_REQ,
   output logic             O_STREAM_OPEN,
   output cam_ctrl_pkg::readout_format_t O_FORMAT,
   output cam_ctrl_pkg::evt_out_t        O_EVT,
   output logic             O_UNIT_REINIT,
   // Non-volatile label memory
   output logic             O_NV_WE,
   output logic      [2:0]  O_NV_ADDR,
   output logic      [31:0] O_NV_WDATA,
   input  wire logic [31:0] I_NV_RDATA
);
   import cam_ctrl_pkg::*;

   // Identity strings kept as parameters; defaults are arbitrary text

   // Bus pipeline
   ahb_req_t          dph_ff;          // Data phase request
   ahb_req_t          nxt_dph;
   logic [31:0]       rdata_ff;        // Read data for the data phase
   logic [31:0]       nxt_rdata;

   // Control state
   logic              stream_ff;       // Stream channel open
   logic              nxt_stream;
   logic              event_ff;        // Event notification on
   logic              nxt_event;
   readout_format_t   format_ff;       // Readout format choice
   readout_format_t   nxt_format;
   logic              refused_ff;      // Sticky: format write refused
   logic              nxt_refused;

   // Output pulses
   evt_out_t          evt_ff;          // Event packet strobe
   evt_out_t          nxt_evt;
   logic              reinit_ff;       // Reinit pulse to the rest of the unit
   logic              nxt_reinit;

   // Wiring
   logic              addr_take;       // Address phase accepted this cycle
   logic              wr_now;          // Write data phase completes
   logic              label_busy;      // Label restore in progress
   logic [31:0]       label_rd;        // Label word at address phase index
   logic              label_wr;        // Label word write this cycle

   // ************************************************************
   // Helpers
   // ************************************************************
   // Word select from a 128-bit string, word 0 holds the first chars
   function automatic logic [31:0] word4(input logic [127:0] s,
                                         input logic [1:0]   i);
      word4 = s[(3 - i) * 32 +: 32];
   endfunction

   // Offset inside a region test
   function automatic logic in_rgn(input logic [7:0] ofs, input logic [7:0] base,
                                   input logic [7:0] size);
      in_rgn = (ofs >= base) && (ofs < base + size);
   endfunction

   // ************************************************************
   // Bus handshake
   // ************************************************************
   // Stall only while labels reload, so no access sees stale label data
   assign O_HREADYOUT = !label_busy;
   assign O_HRESP     = 1'b0;
   assign O_HRDATA    = rdata_ff;
   assign addr_take   = I_HSEL && I_HTRANS[1] && I_HREADY;
   assign wr_now      = dph_ff.valid && dph_ff.write && !label_busy;

   assign label_wr = wr_now && in_rgn(dph_ff.ofs, OFS_LABEL, 8'h20);

   // ************************************************************
   // Label storage
   // ************************************************************
   label_store #(
      .WORDS      (LABEL_WORDS)
   ) u_label (
      .i_clk      (I_CLK_SYS),
      .i_reset    (I_RESET),
      .i_ce       (I_CE),
      .i_wr_en    (label_wr),
      .i_wr_idx   (dph_ff.ofs[4:2]),
      .i_wr_data  (I_HWDATA),
      .i_rd_idx   (I_HADDR[4:2]),
      .o_rd_data  (label_rd),
      .o_busy     (label_busy),
      .o_nv_we    (O_NV_WE),
      .o_nv_addr  (O_NV_ADDR),
      .o_nv_wdata (O_NV_WDATA),
      .i_nv_rdata (I_NV_RDATA)
   );

   // ************************************************************
   // Control registers next state
   // ************************************************************
   always_comb begin
      nxt_stream  = stream_ff;
      nxt_event   = event_ff;
      nxt_format  = format_ff;
      nxt_refused = refused_ff;
      nxt_reinit  = 1'b0;
      nxt_evt     = '0;

      if (event_ff && I_EVT_REQ) begin
         nxt_evt.send = 1'b1;
      end

      if (wr_now) begin
         case (dph_ff.ofs)
            OFS_STREAM: begin
               nxt_stream = I_HWDATA[0];
            end

            OFS_EVENT: begin
               nxt_event = I_HWDATA[0];
            end

            OFS_TEST_EVT: begin
               if (event_ff) begin
                  nxt_evt.send = 1'b1;
                  nxt_evt.test = 1'b1;
               end
            end

            OFS_FORMAT: begin
               if (I_STREAM_BUSY || (I_HWDATA[1:0] == 2'b11)) begin
                  nxt_refused = 1'b1;
               end else begin
                  nxt_format = readout_format_t'(I_HWDATA[1:0]);
               end
            end

            // Clear refused flag by writing one; a new refusal wins
            OFS_STATUS: begin
               if (I_HWDATA[BIT_STAT_REFUSED]) begin
                  nxt_refused = 1'b0;
               end
            end

            OFS_REINIT: begin
               nxt_reinit = 1'b1;
            end

            default: begin
               nxt_reinit = 1'b0;
            end
         endcase
         // Reinit takes priority over the same write's other effects
         if (dph_ff.ofs == OFS_REINIT) begin
            nxt_stream  = RST_STREAM;
            nxt_event   = RST_EVENT;
            nxt_format  = RST_FORMAT;
            nxt_refused = RST_REFUSED;
            nxt_evt     = '0;
         end
      end

      // Refusal set wins over a status clear in the same cycle
      if (wr_now && (dph_ff.ofs == OFS_FORMAT) && I_STREAM_BUSY) begin
         nxt_refused = 1'b1;
      end
   end

   // ************************************************************
   // Bus phase and read data next state
   // ************************************************************
   // Read data is formed from next values so a write just ahead is seen
   always_comb begin
      nxt_dph   = dph_ff;
      nxt_rdata = rdata_ff;
      if (!label_busy) begin
         // Bus frozen while labels reload
         nxt_dph.valid = addr_take;
         nxt_dph.write = I_HWRITE;
         nxt_dph.ofs   = (I_HADDR[31:8] == 24'h0) ? I_HADDR[7:0] : 8'hff;
         nxt_rdata     = 32'h0;
         if (addr_take && !I_HWRITE && (I_HADDR[31:8] == 24'h0)) begin
            if (in_rgn(I_HADDR[7:0], OFS_MAKER, 8'h10)) begin
               nxt_rdata = word4(MAKER_NAME, I_HADDR[3:2]);
            end else if (in_rgn(I_HADDR[7:0], OFS_MODEL, 8'h10)) begin
               nxt_rdata = word4(MODEL_NAME, I_HADDR[3:2]);
            end else if (in_rgn(I_HADDR[7:0], OFS_INFO, 8'h10)) begin
               nxt_rdata = word4(MAKER_INFO, I_HADDR[3:2]);
            end else if (in_rgn(I_HADDR[7:0], OFS_VERSION, 8'h08)) begin
               nxt_rdata = I_HADDR[2] ? UNIT_VER[31:0] : UNIT_VER[63:32];
            end else if (in_rgn(I_HADDR[7:0], OFS_SERIAL, 8'h08)) begin
               nxt_rdata = I_HADDR[2] ? SERIAL_NUM[31:0] : SERIAL_NUM[63:32];
            end else if (in_rgn(I_HADDR[7:0], OFS_LABEL, 8'h20)) begin
               nxt_rdata = label_rd;
            end else begin
               // Control and status words
               case (I_HADDR[7:0])
                  OFS_STREAM: nxt_rdata = {31'h0, nxt_stream};
                  OFS_EVENT:  nxt_rdata = {31'h0, nxt_event};
                  OFS_FORMAT: nxt_rdata = {30'h0, nxt_format};
                  OFS_STATUS: nxt_rdata = {30'h0, nxt_refused, I_STREAM_BUSY};
                  // Write-only and unmapped words read zero
                  default:    nxt_rdata = 32'h0;
               endcase
            end
         end
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         // Controls back to defaults
         dph_ff     <= '0;
         rdata_ff   <= 32'h0;
         stream_ff  <= RST_STREAM;
         event_ff   <= RST_EVENT;
         format_ff  <= RST_FORMAT;
         refused_ff <= RST_REFUSED;
         evt_ff     <= '0;
         reinit_ff  <= 1'b0;
      end else if (I_CE) begin
         // Held while the enable is low
         dph_ff     <= nxt_dph;
         rdata_ff   <= nxt_rdata;
         stream_ff  <= nxt_stream;
         event_ff   <= nxt_event;
         format_ff  <= nxt_format;
         refused_ff <= nxt_refused;
         evt_ff     <= nxt_evt;
         reinit_ff  <= nxt_reinit;
      end
   end

   // ************************************************************
   // Camera side outputs
   // ************************************************************
   assign O_STREAM_OPEN = stream_ff;
   assign O_FORMAT      = format_ff;
   assign O_EVT         = evt_ff;
   assign O_UNIT_REINIT = reinit_ff;

endmodule

// ===== test/nv_label_model.sv
// Non-volatile label memory model on the far side of the bank
`timescale 1ns/10ps
module nv_label_model (
   input  wire logic        i_clk,
   input  wire logic        i_we,
   input  wire logic [2:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   output logic      [31:0] o_rdata
);
   logic [31:0] mem [8];   // Retained words, never cleared by any reset

   initial begin
      for (int k = 0; k < 8; k++) begin
         mem[k] = 32'h5a5a0000 + 32'(k);
      end
   end

   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
   end

   // Read is combinational per address, as the bank expects
   assign o_rdata = mem[i_addr];
endmodule

// ===== test/cam_ctrl_sva.sv
// Assertion checker for the camera control register bank
`timescale 1ns/10ps
module cam_ctrl_sva #(
   parameter logic [127:0] MAKER_NAME = 128'h0   // First identity string of the bank
) (
   input wire logic                          I_CLK_SYS,
   input wire logic                          I_RESET,
   input wire logic                          I_HSEL,
   input wire logic [31:0]                   I_HADDR,
   input wire logic [1:0]                    I_HTRANS,
   input wire logic                          I_HWRITE,
   input wire logic [31:0]                   I_HWDATA,
   input wire logic                          I_HREADY,
   input wire logic                          I_STREAM_BUSY,
   input wire logic [31:0]                   O_HRDATA,
   input wire logic                          O_STREAM_OPEN,
   input wire cam_ctrl_pkg::readout_format_t O_FORMAT,
   input wire cam_ctrl_pkg::evt_out_t        O_EVT,
   input wire logic                          O_UNIT_REINIT,
   input wire logic                          O_NV_WE,
   input wire logic [2:0]                    O_NV_ADDR,
   input wire logic [31:0]                   O_NV_WDATA
);
   import cam_ctrl_pkg::*;
   logic       dp_v_ff, nxt_dp_v;   // Data phase of a mapped transfer
   logic       dp_w_ff, nxt_dp_w;   // That transfer writes
   logic [7:0] dp_o_ff, nxt_dp_o;   // Its byte offset
   logic       ev_ff, nxt_ev;       // Shadow of the event enable
   logic       wr_any, wr_str, wr_fmt, wr_tst, wr_rein, wr_lbl, rd_mkr;

   assign wr_any  = dp_v_ff & dp_w_ff & I_HREADY;
   assign wr_str  = wr_any & (dp_o_ff == OFS_STREAM);
   assign wr_fmt  = wr_any & (dp_o_ff == OFS_FORMAT);
   assign wr_tst  = wr_any & (dp_o_ff == OFS_TEST_EVT);
   assign wr_rein = wr_any & (dp_o_ff == OFS_REINIT);
   assign wr_lbl  = wr_any & (dp_o_ff[7:5] == 3'h1);
   assign rd_mkr  = dp_v_ff & ~dp_w_ff & I_HREADY & (dp_o_ff == OFS_MAKER);

   // Track the data phase; a stalled phase keeps its request
   always_comb begin
      nxt_dp_v = dp_v_ff;
      nxt_dp_w = dp_w_ff;
      nxt_dp_o = dp_o_ff;
      nxt_ev   = ev_ff;
      if (I_HREADY) begin
         nxt_dp_v = I_HSEL & I_HTRANS[1] & (I_HADDR[31:8] == 24'h0);
         nxt_dp_w = I_HWRITE;
         nxt_dp_o = I_HADDR[7:0];
      end
      if (wr_any && dp_o_ff == OFS_EVENT) begin
         nxt_ev = I_HWDATA[0];
      end else if (wr_rein) begin
         nxt_ev = RST_EVENT;
      end
   end

   // Register helper state
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         dp_v_ff <= 1'b0;
         ev_ff   <= RST_EVENT;
      end else begin
         dp_v_ff <= nxt_dp_v;
         ev_ff   <= nxt_ev;
      end
      dp_w_ff <= nxt_dp_w;
      dp_o_ff <= nxt_dp_o;
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RESET);

   stream_write_a: assert property (wr_str |=> O_STREAM_OPEN == $past(I_HWDATA[0]))
      else $error("stream open differs from written bit");
   reset_default_a: assert property ($fell(I_RESET) |-> O_FORMAT == RST_FORMAT
      && !O_STREAM_OPEN)
      else $error("format or stream not at default after reset");
   format_take_a: assert property ((wr_fmt && !I_STREAM_BUSY && I_HWDATA[1:0] != 2'h3)
      |=> O_FORMAT == $past(I_HWDATA[1:0]))
      else $error("format write not taken");
   format_busy_a: assert property (wr_fmt && I_STREAM_BUSY |=> $stable(O_FORMAT))
      else $error("format changed while streaming");
   event_gate_a: assert property (O_EVT.send |-> $past(ev_ff))
      else $error("event packet sent while disabled");
   test_fire_a: assert property (wr_tst && ev_ff |=> O_EVT.send && O_EVT.test)
      else $error("test event packet missing");
   reinit_clear_a: assert property (wr_rein |=> O_UNIT_REINIT && !O_STREAM_OPEN
      && O_FORMAT == RST_FORMAT)
      else $error("reinit did not restore controls");
   label_nv_a: assert property (wr_lbl |=> O_NV_WE && O_NV_ADDR == $past(dp_o_ff[4:2])
      && O_NV_WDATA == $past(I_HWDATA))
      else $error("label word not written to storage");
   maker_read_a: assert property (rd_mkr |-> O_HRDATA == MAKER_NAME[127:96])
      else $error("maker name word wrong");

   cover property (wr_tst && ev_ff);
   cover property (wr_fmt && I_STREAM_BUSY);
   cover property (wr_rein);
endmodule

bind camera_control_registers cam_ctrl_sva #(.MAKER_NAME(MAKER_NAME)) u_sva (
   .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
   .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY),
   .I_STREAM_BUSY(I_STREAM_BUSY), .O_HRDATA(O_HRDATA), .O_STREAM_OPEN(O_STREAM_OPEN),
   .O_FORMAT(O_FORMAT), .O_EVT(O_EVT), .O_UNIT_REINIT(O_UNIT_REINIT), .O_NV_WE(O_NV_WE),
   .O_NV_ADDR(O_NV_ADDR), .O_NV_WDATA(O_NV_WDATA));

// ===== test/test_camera_control_registers.sv
// Self-checking bench for the camera control register bank
`timescale 1ns/10ps
module test_camera_control_registers;
   import cam_ctrl_pkg::*;
   // Arbitrary identity words, all distinct to expose misordering
   function automatic logic [511:0] mk_id();
      logic [511:0] v;
      v = '0;
      for (int k = 0; k < 16; k++) begin
         v[511-32*k -: 32] = 32'h1d0c0000 + 32'(k);
      end
      return v;
   endfunction
   localparam logic [511:0] ID_ALL = mk_id();

   logic            clk, rst, ce, hsel, hwrite, hready, hresp, busy, evt_req;
   logic            st_open, reinit, nv_we;
   logic [1:0]      htrans;
   logic [2:0]      nv_addr;
   logic [31:0]     haddr, hwdata, hrdata, nv_wdata, nv_rdata, rd;
   readout_format_t fmt;
   evt_out_t        evt;
   int              err_total, num_checks, n_send, n_test, n_reinit;

   camera_control_registers #(
      .MAKER_NAME(ID_ALL[511:384]), .MODEL_NAME(ID_ALL[383:256]),
      .MAKER_INFO(ID_ALL[255:128]), .UNIT_VER(ID_ALL[127:64]), .SERIAL_NUM(ID_ALL[63:0])
   ) dut (
      .I_CLK_SYS(clk), .I_RESET(rst), .I_CE(ce), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp),
      .I_STREAM_BUSY(busy), .I_EVT_REQ(evt_req), .O_STREAM_OPEN(st_open), .O_FORMAT(fmt),
      .O_EVT(evt), .O_UNIT_REINIT(reinit), .O_NV_WE(nv_we), .O_NV_ADDR(nv_addr),
      .O_NV_WDATA(nv_wdata), .I_NV_RDATA(nv_rdata));

   nv_label_model u_nv (.i_clk(clk), .i_we(nv_we), .i_addr(nv_addr), .i_wdata(nv_wdata),
      .o_rdata(nv_rdata));

   // Count pulses as they stand at each edge
   always @(posedge clk) begin
      n_send   += evt.send;
      n_test   += evt.send & evt.test;
      n_reinit += reinit;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Returns at the edge that samples hready high; hrdata is taken there
   task automatic wait_rdy();
      @(posedge clk);
      while (hready !== 1'b1) begin
         @(posedge clk);
      end
      rd = hrdata;
   endtask

   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= wr;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask

   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      xfer(1'b1, {24'h0, o}, d);
      repeat (3) @(negedge clk);
   endtask

   task automatic rdchk(input logic [7:0] o, input logic [31:0] exp);
      xfer(1'b0, {24'h0, o}, 32'h0);
      chk(rd, exp);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Cuts a hang short; the sequence needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      final_report();
   end

   initial begin
      {rst, ce, hsel, hwrite, busy, evt_req} = 6'h30;
      {htrans, haddr, hwdata} = '0;
      {err_total, num_checks, n_send, n_test, n_reinit} = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(32'(hready), 32'h0);
      rdchk(OFS_STREAM, 32'h0);
      rdchk(OFS_EVENT, 32'h0);
      rdchk(OFS_FORMAT, 32'h0);
      for (int k = 0; k < 8; k++) rdchk(OFS_LABEL + 8'(4*k), 32'h5a5a0000 + 32'(k));
      wr(OFS_STREAM, 32'h1);
      chk(32'(st_open), 32'h1);
      wr(OFS_STREAM, 32'h0);
      chk(32'(st_open), 32'h0);
      for (int f = 1; f < 4; f++) begin
         wr(OFS_FORMAT, 32'(f % 3));
         chk(32'(fmt), 32'(f % 3));
      end
      wr(OFS_FORMAT, 32'h3);
      rdchk(OFS_FORMAT, 32'h0);
      rdchk(OFS_STATUS, 32'h2);
      wr(OFS_STATUS, 32'h2);
      rdchk(OFS_STATUS, 32'h0);
      @(posedge clk);
      busy <= 1'b1;
      wr(OFS_FORMAT, 32'h1);
      chk(32'(fmt), 32'h0);
      rdchk(OFS_STATUS, 32'h3);
      @(posedge clk);
      busy <= 1'b0;
      wr(OFS_FORMAT, 32'h1);
      chk(32'(fmt), 32'h1);
      // Events dropped while notification is off, then sent
      for (int e = 0; e < 2; e++) begin
         wr(OFS_TEST_EVT, 32'h0);
         @(posedge clk);
         evt_req <= 1'b1;
         @(posedge clk);
         evt_req <= 1'b0;
         repeat (3) @(negedge clk);
         chk(32'(n_send), 32'(2*e));
         chk(32'(n_test), 32'(e));
         wr(OFS_EVENT, 32'h1);
      end
      // Clock enable low: a request in that cycle is not seen
      @(posedge clk);
      {ce, evt_req} <= 2'b01;
      @(posedge clk);
      {ce, evt_req} <= 2'b10;
      repeat (3) @(negedge clk);
      chk(32'(n_send), 32'h2);
      for (int k = 0; k < 16; k++) rdchk(OFS_MAKER + 8'(4*k), ID_ALL[511-32*k -: 32]);
      wr(OFS_MAKER, 32'hffffffff);
      rdchk(OFS_MAKER, ID_ALL[511:480]);
      xfer(1'b0, 32'h00000100, 32'h0);
      chk(rd, 32'h0);
      chk(32'(hresp), 32'h0);
      for (int k = 0; k < 8; k++) wr(OFS_LABEL + 8'(4*k), 32'hc0de0000 + 32'(k));
      for (int k = 0; k < 8; k++) chk(u_nv.mem[k], 32'hc0de0000 + 32'(k));
      wr(OFS_STREAM, 32'h1);
      wr(OFS_FORMAT, 32'h2);
      wr(OFS_REINIT, 32'h0);
      chk(32'(n_reinit), 32'h1);
      chk({st_open, 29'h0, fmt}, 32'h0);
      rdchk(OFS_EVENT, 32'h0);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 8; k++) rdchk(OFS_LABEL + 8'(4*k), 32'hc0de0000 + 32'(k));
      final_report();
   end
endmodule
